//--- src/aic_pkg.sv
// package for the ata identify and idle command block
package aic_pkg;
   // apb register offsets (byte addresses)
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_W85 = 8'h0C;
   localparam logic [7:0] OFS_W86 = 8'h10;
   localparam logic [7:0] OFS_W87 = 8'h14;
   localparam logic [7:0] OFS_W88 = 8'h18;
   localparam logic [7:0] OFS_W93 = 8'h1C;
   localparam logic [7:0] OFS_W128 = 8'h20;
   localparam logic [7:0] OFS_GEOM = 8'h24;
   localparam logic [7:0] OFS_SEC = 8'h28;
   // command opcodes
   localparam logic [7:0] OP_IDLE_A = 8'h97;
   localparam logic [7:0] OP_IDLE_B = 8'hE3;
   localparam logic [7:0] OP_IMM_A = 8'h95;
   localparam logic [7:0] OP_IMM_B = 8'hE1;
   localparam logic [7:0] OP_INIT = 8'h91;
   // fixed identify word values
   localparam logic [15:0] W85_FIXED = 16'h7008;
   localparam logic [15:0] W87_FIXED = 16'h4000;
   localparam logic [15:0] W93_FIXED = 16'h4000;
   // timing: 5 ms tick at 40 MHz
   localparam int CLK_HZ = 40000000;
   localparam int TICK_MS = 5;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   // reset values
   localparam logic [7:0] RST_SPT = 8'h00;
   localparam logic [3:0] RST_HEADS = 4'h0;
   typedef enum logic [1:0] {AIC_IDLE, AIC_BUSY, AIC_DONE} aic_state_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] sec_cnt;
      logic [7:0] drv_head;
   } aic_cmd_t;
endpackage : aic_pkg

//--- src/aic_top.sv
// ata identify words, idle, idle immediate and init drive parameters with apb access
// Behaviour
// - word 87 returns bit 14 one and bit 15 zero.
// - word 86 bits 15..4, 2..0 and word 87 bits 13..0 reserved, read zero.
// - word 85 bits 0,2,4,7-10 zero, bits 3,12,13,14 one.
// - word 85 bits 1,5,6 from security, write cache, look-ahead state.
// - word 86 bit 3 only when advanced power management enabled.
// - at most one dma mode selected; udma and mdma exclude each other.
// - word 88 zero outside native interface mode or without udma support.
// - word 88 bits 14..8 flag selected udma mode 6..0.
// - udma support bits cumulative: each set bit implies all lower.
// - word 93 bits 12..0 change only during hardware reset; 15=0, 14=1.
// - word 93 bit 13 set when cable identify line high.
// - device 0 clears 12..8; device 1 reports pdiag, method, bit 8 one.
// - device 1 clears 7..0; device 0 reports its reset result there.
// - word 128 reports security status fields, other bits zero.
// - idle opcode 97h/e3h: busy, enter idle, release busy, interrupt.
// - idle nonzero count loads 5 ms power-down timer; zero disables it.
// - idle immediate 95h/e1h does the same without touching the timer enable or count; the count restarts as for any command.
// - 91h takes sectors per track and heads minus one only.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module aic_top #(
   parameter int TICK_CYCLES = aic_pkg::TICK_CYC,
   parameter logic [6:0] UDMA_SUPPORT = 7'h1F
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cblid_pin,
   input wire logic native_drive_interface_mode,
   input wire logic hw_reset_active,
   output logic busy,
   output logic intrq,
   output logic idle_mode,
   output logic power_down
);
   import aic_pkg::*;

   typedef struct packed {
      aic_state_t st;
      aic_cmd_t cmd;
      logic busy;
      logic intrq;
      logic idle;
      logic pdown;
      logic apd_en;
      logic [7:0] apd_val;
      logic [7:0] apd_ticks;
      logic [31:0] tick_cnt;
      logic [7:0] spt;
      logic [3:0] heads_m1;
      logic sec_en;
      logic wcache;
      logic lookahead;
      logic apm;
      logic [6:0] udma_sel;
      logic [2:0] mdma_sel;
      logic sec_sup;
      logic sec_lvl;
      logic sec_enh;
      logic sec_exp;
      logic sec_frz;
      logic sec_lck;
      logic dev1;
      logic [1:0] method;
      logic diag_pass;
      logic pdiag_seen;
      logic dasp_seen;
      logic dev1_resp;
      logic [12:0] w93_low;
      logic cable80;
      logic [2:0] cbl_sync;
      logic [31:0] rdata;
   } aic_regs_t;

   aic_regs_t r;
   aic_regs_t next_r;
   logic wr_acc;
   logic rd_acc;
   logic [15:0] w85;
   logic [15:0] w86;
   logic [15:0] w87;
   logic [15:0] w88;
   logic [15:0] w93;
   logic [15:0] w128;
   logic [6:0] udma_cum;
   logic mapped;

   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   // cumulative support mask: highest supported mode fills all lower bits
   always_comb begin
      udma_cum = '0;
      for (int i = 6; i >= 0; i--) begin
         if (UDMA_SUPPORT[i] || (i < 6 && udma_cum[i+1])) begin
            udma_cum[i] = 1'b1;
         end
      end
   end

   // identify words assembled from state
   always_comb begin
      w85 = W85_FIXED;
      w85[1] = r.sec_en;
      w85[5] = r.wcache;
      w85[6] = r.lookahead;
      w86 = 16'h0000;
      w86[3] = r.apm;
      w87 = W87_FIXED;
      if (native_drive_interface_mode && (udma_cum != 7'h00)) begin
         w88 = {1'b0, r.udma_sel, 1'b0, udma_cum};
      end else begin
         w88 = 16'h0000;
      end
      w93 = W93_FIXED | {2'b00, r.cable80, r.w93_low};
      w128 = {7'h00, r.sec_lvl, 2'b00, r.sec_enh, r.sec_exp, r.sec_frz, r.sec_lck, r.sec_en, r.sec_sup};
   end

   // next-state logic: apb writes, command engine, timer, reset result
   always_comb begin
      next_r = r;
      mapped = 1'b1;
      // cable identify synchroniser, three stages
      next_r.cbl_sync = {r.cbl_sync[1:0], cblid_pin};
      if (r.cbl_sync[2] == r.cbl_sync[1]) begin
         next_r.cable80 = r.cbl_sync[1];
      end
      // reset result words captured only while hardware reset runs
      if (hw_reset_active) begin
         if (r.dev1) begin
            next_r.w93_low = {1'b0, r.pdiag_seen, r.method, 1'b1, 8'h00};
         end else begin
            next_r.w93_low = {5'h00, 1'b0, r.dev1_resp, r.dasp_seen, r.pdiag_seen,
               r.diag_pass, r.method, 1'b1};
         end
      end
      // command engine
      case (r.st)
         AIC_IDLE: begin
         end
         AIC_BUSY: begin
            next_r.busy = 1'b0;
            next_r.st = AIC_DONE;
            if (r.cmd.opcode == OP_IDLE_A || r.cmd.opcode == OP_IDLE_B) begin
               next_r.idle = 1'b1;
               next_r.pdown = 1'b0;
               next_r.apd_en = (r.cmd.sec_cnt != 8'h00);
               next_r.apd_val = r.cmd.sec_cnt;
            end else if (r.cmd.opcode == OP_IMM_A || r.cmd.opcode == OP_IMM_B) begin
               next_r.idle = 1'b1;
               next_r.pdown = 1'b0;
            end else if (r.cmd.opcode == OP_INIT) begin
               next_r.spt = r.cmd.sec_cnt;
               next_r.heads_m1 = r.cmd.drv_head[3:0];
            end
         end
         AIC_DONE: begin
            next_r.intrq = 1'b1;
            next_r.st = AIC_IDLE;
         end
         default: next_r.st = AIC_IDLE;
      endcase
      // auto power-down timer
      if (r.apd_en && !r.pdown && r.st == AIC_IDLE) begin
         if (r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            next_r.tick_cnt = '0;
            if (r.apd_ticks + 8'h01 >= r.apd_val) begin
               next_r.pdown = 1'b1;
               next_r.idle = 1'b0;
            end else begin
               next_r.apd_ticks = r.apd_ticks + 8'h01;
            end
         end else begin
            next_r.tick_cnt = r.tick_cnt + 32'd1;
         end
      end
      // apb register writes
      if (wr_acc) begin
         if (paddr == OFS_CMD) begin
            if (r.st == AIC_IDLE) begin
               next_r.cmd = pwdata[23:0];
               next_r.busy = 1'b1;
               next_r.intrq = 1'b0;
               next_r.st = AIC_BUSY;
               next_r.tick_cnt = '0;
               next_r.apd_ticks = 8'h00;
            end
         end else if (paddr == OFS_CFG) begin
            next_r.wcache = pwdata[0];
            next_r.lookahead = pwdata[1];
            next_r.apm = pwdata[2];
            if (pwdata[3]) begin
               next_r.udma_sel = 7'(1 << pwdata[6:4]) & udma_cum;
               next_r.mdma_sel = 3'h0;
            end else if (pwdata[7]) begin
               next_r.mdma_sel = 3'(1 << pwdata[9:8]);
               next_r.udma_sel = 7'h00;
            end
            next_r.dev1 = pwdata[10];
            next_r.method = pwdata[12:11];
            next_r.diag_pass = pwdata[13];
            next_r.pdiag_seen = pwdata[14];
            next_r.dasp_seen = pwdata[15];
            next_r.dev1_resp = pwdata[16];
         end else if (paddr == OFS_SEC) begin
            next_r.sec_sup = pwdata[0];
            next_r.sec_en = pwdata[1];
            next_r.sec_lck = pwdata[2];
            next_r.sec_frz = pwdata[3];
            next_r.sec_exp = pwdata[4];
            next_r.sec_enh = pwdata[5];
            next_r.sec_lvl = pwdata[8];
         end else if (paddr == OFS_STAT) begin
            // writing one to bit 1 acknowledges the interrupt; a new set wins
            if (pwdata[1] && r.st != AIC_DONE) begin
               next_r.intrq = 1'b0;
            end
         end else begin
            mapped = 1'b0;
         end
      end
      // apb read data
      if (rd_acc) begin
         if (paddr == OFS_STAT) begin
            next_r.rdata = {26'h0, r.mdma_sel != 3'h0, r.apd_en, r.pdown, r.idle, r.intrq, r.busy};
         end else if (paddr == OFS_W85) begin
            next_r.rdata = {16'h0, w85};
         end else if (paddr == OFS_W86) begin
            next_r.rdata = {16'h0, w86};
         end else if (paddr == OFS_W87) begin
            next_r.rdata = {16'h0, w87};
         end else if (paddr == OFS_W88) begin
            next_r.rdata = {16'h0, w88};
         end else if (paddr == OFS_W93) begin
            next_r.rdata = {16'h0, w93};
         end else if (paddr == OFS_W128) begin
            next_r.rdata = {16'h0, w128};
         end else if (paddr == OFS_GEOM) begin
            next_r.rdata = {20'h0, r.heads_m1, r.spt};
         end else if (paddr == OFS_CFG) begin
            next_r.rdata = {9'h0, r.mdma_sel, r.udma_sel, 13'h0};
         end else if (paddr == OFS_CMD) begin
            next_r.rdata = {8'h0, r.cmd};
         end else begin
            next_r.rdata = 32'h0000_0000;
            mapped = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.st <= AIC_IDLE;
         r.spt <= RST_SPT;
         r.heads_m1 <= RST_HEADS;
      end else begin
         r <= next_r;
      end
   end

   // apb answers in the access cycle; read data registered one edge earlier is not used
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = next_r.rdata;
   assign busy = r.busy;
   assign intrq = r.intrq;
   assign idle_mode = r.idle;
   assign power_down = r.pdown;

   // word 87 validity marker
   a_w87_valid: assert property (@(posedge clk) disable iff (rst)
      w87 == 16'h4000) else $error("word 87 marker wrong");
   // fixed bits of word 85
   a_w85_fixed: assert property (@(posedge clk) disable iff (rst)
      (w85 & 16'h779D) == 16'h7008) else $error("word 85 fixed bits wrong");
   // only bit 3 of word 86 can be set
   a_w86_resv: assert property (@(posedge clk) disable iff (rst)
      (w86 & 16'hFFF7) == 16'h0000 && w86[3] == r.apm) else $error("word 86 wrong");
   // udma and mdma selections exclusive
   a_dma_excl: assert property (@(posedge clk) disable iff (rst)
      $onehot0({r.udma_sel, r.mdma_sel})) else $error("two dma modes selected");
   // word 88 zero outside native mode
   a_w88_zero: assert property (@(posedge clk) disable iff (rst)
      !native_drive_interface_mode |-> w88 == 16'h0000) else $error("word 88 not zero");
   // cumulative support
   a_udma_cum: assert property (@(posedge clk) disable iff (rst)
      ((udma_cum + 7'h01) & udma_cum) == 7'h00) else $error("support bits not cumulative");
   // reset result only changes in hardware reset
   a_w93_hold: assert property (@(posedge clk) disable iff (rst)
      !$past(hw_reset_active) |-> $stable(r.w93_low)) else $error("word 93 changed");
   // command sequence: busy one cycle then interrupt
   sequence s_cmd_take;
      wr_acc && paddr == OFS_CMD && r.st == AIC_IDLE;
   endsequence
   sequence s_cmd_done;
      busy ##1 !busy ##1 intrq;
   endsequence
   a_idle_seq: assert property (@(posedge clk) disable iff (rst)
      s_cmd_take |=> s_cmd_done) else $error("command sequence wrong");
   // idle with zero count disables power-down
   a_apd_off: assert property (@(posedge clk) disable iff (rst)
      r.st == AIC_BUSY && (r.cmd.opcode == OP_IDLE_A || r.cmd.opcode == OP_IDLE_B)
      |=> r.apd_en == ($past(r.cmd.sec_cnt) != 8'h00) && r.apd_val == $past(r.cmd.sec_cnt))
      else $error("power-down enable wrong");
   // init params capture
   a_init_geom: assert property (@(posedge clk) disable iff (rst)
      r.st == AIC_BUSY && r.cmd.opcode == OP_INIT |=> r.spt == $past(r.cmd.sec_cnt)
      && r.heads_m1 == $past(r.cmd.drv_head[3:0])) else $error("geometry not taken");

   // fixed top bits of the reset result word
   a_w93_top: assert property (@(posedge clk) disable iff (rst)
      w93[15:14] == 2'b01) else $error("word 93 top bits wrong");
   // cable flag follows the synchroniser once two stages agree
   a_cable_take: assert property (@(posedge clk) disable iff (rst)
      r.cbl_sync[2] == r.cbl_sync[1] |=> r.cable80 == $past(r.cbl_sync[1]))
      else $error("cable flag not taken");
   // device 0 leaves the device 1 field clear
   a_dev0_clear: assert property (@(posedge clk) disable iff (rst)
      hw_reset_active && !r.dev1 |=> r.w93_low[12:8] == 5'h00 && r.w93_low[0])
      else $error("device 0 reset result wrong");
   // device 1 leaves the device 0 field clear and sets bit 8
   a_dev1_clear: assert property (@(posedge clk) disable iff (rst)
      hw_reset_active && r.dev1 |=> r.w93_low[7:0] == 8'h00 && r.w93_low[8] && !r.w93_low[12])
      else $error("device 1 reset result wrong");
   // reserved bits of the security word
   a_w128_resv: assert property (@(posedge clk) disable iff (rst)
      (w128 & 16'hFEC0) == 16'h0000) else $error("word 128 reserved bits set");
   // selected udma field holds at most one mode, reserved bits clear
   a_w88_sel: assert property (@(posedge clk) disable iff (rst)
      !w88[15] && !w88[7] && $onehot0(w88[14:8])) else $error("word 88 selection wrong");
   // idle immediate leaves the power-down timer settings alone
   a_imm_timer: assert property (@(posedge clk) disable iff (rst)
      r.st == AIC_BUSY && (r.cmd.opcode == OP_IMM_A || r.cmd.opcode == OP_IMM_B)
      |=> $stable(r.apd_en) && $stable(r.apd_val)) else $error("idle immediate touched timer");
   // init drive parameters touches neither timer settings nor idle state
   a_init_only: assert property (@(posedge clk) disable iff (rst)
      r.st == AIC_BUSY && r.cmd.opcode == OP_INIT
      |=> $stable(r.apd_en) && $stable(r.apd_val) && $stable(r.idle)) else $error("init changed other state");
   // every accepted command restarts the power-down count
   a_cmd_restart: assert property (@(posedge clk) disable iff (rst)
      s_cmd_take |=> r.tick_cnt == 32'h0 && r.apd_ticks == 8'h00) else $error("timer not restarted");
   // power-down only entered from an enabled timer while the engine idles
   a_pdown_src: assert property (@(posedge clk) disable iff (rst)
      $rose(power_down) |-> $past(r.apd_en) && $past(r.st) == AIC_IDLE) else $error("power-down without timer");
   // interrupt stays until acknowledged or a new command is taken
   a_intrq_hold: assert property (@(posedge clk) disable iff (rst)
      intrq && !(wr_acc && paddr == OFS_STAT && pwdata[1]) && !(wr_acc && paddr == OFS_CMD)
      |=> intrq) else $error("interrupt dropped");
   // busy only rises after a command write
   a_busy_cause: assert property (@(posedge clk) disable iff (rst)
      $rose(busy) |-> $past(wr_acc) && $past(paddr) == OFS_CMD) else $error("busy without command");
endmodule // aic_top
`default_nettype wire

//--- test/aic_host_model.sv
// host side pin model: cable id line, native mode level and hardware reset strobe
`timescale 1ns/1ps
`default_nettype none
module aic_host_model (
   input wire logic clk,
   output var logic cblid_pin,
   output var logic native_drive_interface_mode,
   output var logic hw_reset_active
);
   // pins start quiet, native mode on
   initial begin
      cblid_pin = 1'b0;
      native_drive_interface_mode = 1'b1;
      hw_reset_active = 1'b0;
   end
   // let the cable line settle past the synchroniser, then strobe reset
   task hw_reset(input logic cbl);
      @(posedge clk);
      cblid_pin <= cbl;
      repeat (5) @(posedge clk);
      hw_reset_active <= 1'b1;
      repeat (2) @(posedge clk);
      hw_reset_active <= 1'b0;
   endtask
   // interface mode change from the host side
   task set_native(input logic on);
      @(posedge clk);
      native_drive_interface_mode <= on;
   endtask
   // feature words of 0000h or ffffh carry no enable information
   function automatic logic words_valid(input logic [31:0] w);
      return w[15:0] != 16'h0000 && w[15:0] != 16'hFFFF;
   endfunction
endmodule // aic_host_model
`default_nettype wire

//--- test/aic_top_tb_top.sv
// self-checking bench for the identify word and idle command block
`timescale 1ns/1ps
`default_nettype none
module aic_top_tb_top;
   import aic_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, cblid_pin, native_drive_interface_mode, hw_reset_active;
   logic busy, intrq, idle_mode, power_down, last_err;
   logic [31:0] q;
   int error_cnt = 0;
   int checks = 0;
   logic [7:0] idle_op [2] = '{OP_IDLE_A, OP_IDLE_B};
   logic [7:0] imm_op [2] = '{OP_IMM_A, OP_IMM_B};
   // 25 ns clock
   always #12.5 clk = ~clk;
   aic_host_model aic_host_model_i (.clk(clk), .cblid_pin(cblid_pin),
      .native_drive_interface_mode(native_drive_interface_mode), .hw_reset_active(hw_reset_active));
   aic_top #(.TICK_CYCLES(10)) aic_top_i (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cblid_pin(cblid_pin),
      .native_drive_interface_mode(native_drive_interface_mode), .hw_reset_active(hw_reset_active),
      .busy(busy), .intrq(intrq), .idle_mode(idle_mode), .power_down(power_down));
   // verdict and end of run
   task end_of_test();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer: setup, access held until pready
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      chk(pready, 1'b1); // a wait that runs out counts as a mismatch
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   // command write, then busy, release and interrupt in order
   task cmd(input logic [7:0] op, input logic [7:0] sc);
      apb(1'b1, OFS_CMD, {8'h00, op, sc, 8'h00});
      #1 chk(busy, 1'b1);
      @(posedge clk);
      #1 chk({busy, idle_mode, power_down}, 3'b010);
      @(posedge clk);
      #1 chk(intrq, 1'b1);
      apb(1'b1, OFS_STAT, 32'h2);
      #1 chk(intrq, 1'b0);
   endtask
   // bounded wait for power-down
   task wait_pd();
      int n;
      n = 0;
      while (power_down !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
   endtask
   task t_features();
      rd(OFS_W85, 32'h7008, 32'hFFFF_FFFF);
      rd(OFS_W86, 32'h0, 32'hFFFF_FFFF);
      rd(OFS_W87, 32'h4000, 32'hFFFF_FFFF);
      chk(aic_host_model_i.words_valid(q), 1'b1);
      apb(1'b1, OFS_CFG, 32'h7);
      apb(1'b1, OFS_SEC, 32'h13F);
      rd(OFS_W85, 32'h706A, 32'hFFFF_FFFF);
      rd(OFS_W86, 32'h0008, 32'hFFFF_FFFF);
      rd(OFS_W128, 32'h013F, 32'hFFFF_FFFF);
      apb(1'b1, OFS_SEC, 32'h12C);
      rd(OFS_W128, 32'h012C, 32'hFFFF_FFFF);
      apb(1'b1, OFS_CFG, 32'h0);
      rd(OFS_W85, 32'h7008, 32'hFFFF_FFFF);
      rd(8'h3C, 32'h0, 32'hFFFF_FFFF);
      chk(last_err, 1'b1);
   endtask
   task t_dma();
      apb(1'b1, OFS_CFG, 32'h28);
      rd(OFS_W88, 32'h041F, 32'hFFFF_FFFF);
      rd(OFS_STAT, 32'h0, 32'h20);
      apb(1'b1, OFS_CFG, 32'h180);
      rd(OFS_W88, 32'h001F, 32'hFFFF_FFFF);
      rd(OFS_STAT, 32'h20, 32'h20);
      apb(1'b1, OFS_CFG, 32'h08);
      rd(OFS_W88, 32'h011F, 32'hFFFF_FFFF);
      rd(OFS_STAT, 32'h0, 32'h20);
      aic_host_model_i.set_native(1'b0);
      rd(OFS_W88, 32'h0, 32'hFFFF_FFFF);
      aic_host_model_i.set_native(1'b1);
   endtask
   task t_reset_word();
      apb(1'b1, OFS_CFG, 32'h1A800);
      aic_host_model_i.hw_reset(1'b1);
      rd(OFS_W93, 32'h606B, 32'hFFFF_FFFF);
      apb(1'b1, OFS_CFG, 32'h5400);
      rd(OFS_W93, 32'h606B, 32'hFFFF_FFFF);
      aic_host_model_i.hw_reset(1'b0);
      rd(OFS_W93, 32'h4D00, 32'hFFFF_FFFF);
   endtask
   task t_idle();
      for (int i = 0; i < 2; i++) begin
         cmd(idle_op[i], 8'd3);
         rd(OFS_STAT, 32'h10, 32'h10);
         repeat (15) @(posedge clk);
         #1 chk(power_down, 1'b0);
         wait_pd();
         chk(power_down, 1'b1);
         cmd(imm_op[i], 8'd0);
         rd(OFS_STAT, 32'h10, 32'h10);
         wait_pd();
         chk(power_down, 1'b1);
      end
      cmd(OP_IDLE_A, 8'd0);
      rd(OFS_STAT, 32'h0, 32'h10);
      repeat (80) @(posedge clk);
      #1 chk(power_down, 1'b0);
   endtask
   task t_geom();
      apb(1'b1, OFS_CMD, {8'h00, OP_INIT, 8'h3F, 8'hA5});
      repeat (4) @(posedge clk);
      apb(1'b1, OFS_STAT, 32'h2);
      rd(OFS_GEOM, 32'h053F, 32'hFFF);
      chk(last_err, 1'b0);
   endtask
   // watchdog
   initial begin
      #(25 * 20000);
      error_cnt++;
      end_of_test();
   end
   // reset, then scenarios
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_features();
      t_dma();
      t_reset_word();
      t_idle();
      t_geom();
      end_of_test();
   end
endmodule // aic_top_tb_top
`default_nettype wire
